// file: hdl/wbfs_top.sv
// Purpose: Write buffer, load miss silo, pending fill latch and bus arbiter
// Assumes: One core clock; bus interface unit on the far side is logic
// Notes: Replayed silo loads always fetch a line; they are never re-probed
`timescale 1ns/100ps
`include "wbfs_params.svh"
// Overview of operation
// R1 - Arbiter order: data fill, instruction fill, buffer
// R2 - Fills arrive as four 64-bit transfers
// R3 - Buffer entry unloads in up to four transfers
// R4 - Exactly four entries, each one aligned block
// R5 - Insert at tail, unload at head, pointers advance
// R6 - Equal pointers mean empty or full, told apart
// R7 - Stores may merge into a matching entry
// R8 - Otherwise entries leave in insertion order
// R9 - Barrier, conditional store, prefetch never merge
// R10 - Two or more entries request unload
// R11 - Lone entry unloads after 256 idle cycles
// R12 - Barrier or conditional store forces unload
// R13 - Load miss hitting buffer drains whole buffer
// R14 - Miss holds address-unit issue except zero-register jump
// R15 - Two younger operations may follow a miss
// R16 - Younger hits complete under the miss
// R17 - Younger misses siloed, replayed in order
// R18 - Stores siloed, reach buffer in order
// R19 - Requested quadword arrives first
// R20 - Fill quadwords gather in a holding latch
// R21 - Issue resumes on empty silo and quadword
// R22 - Full line written when array is free
// R23 - Reset empties buffer, silo and idle counter
module wbfs_top (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic issue_abox_i,
  input wire logic issue_jsr_zero_i,
  output logic issue_hold_o,
  input wire logic mem_valid_i,
  input wire wbfs_pkg::wbfs_memop_t mem_op_i,
  input wire logic mem_hit_i,
  output logic mem_ready_o,
  output logic miss_qw_valid_o,
  output logic [`WBFS_QW_W-1:0] miss_qw_o,
  input wire logic ifill_req_i,
  input wire logic [`WBFS_BLK_W-1:0] ifill_blk_i,
  output logic ic_beat_valid_o,
  output logic [`WBFS_QW_W-1:0] ic_beat_o,
  input wire logic dc_busy_i,
  output logic dc_fill_we_o,
  output logic [`WBFS_BLK_W-1:0] dc_fill_blk_o,
  output logic [`WBFS_BEATS*`WBFS_QW_W-1:0] dc_fill_line_o,
  output wbfs_pkg::wbfs_cmd_t biu_cmd_o,
  input wire logic biu_cmd_ack_i,
  input wire logic biu_rvalid_i,
  input wire logic [`WBFS_QW_W-1:0] biu_rdata_i,
  output logic biu_wvalid_o,
  output logic [`WBFS_QW_W-1:0] biu_wdata_o,
  input wire logic biu_wready_i
);
  typedef enum {WBFS_F_IDLE, WBFS_F_REQ, WBFS_F_COLLECT, WBFS_F_WRITE} wbfs_fill_t;
  typedef enum {WBFS_A_IDLE, WBFS_A_CMD, WBFS_A_DATA} wbfs_arb_t;

  // Count of set bits in the entry valid vector
  function automatic logic [`WBFS_CNT_W-1:0] wbfs_count(input logic [`WBFS_WB_ENTRIES-1:0] v);
    logic [`WBFS_CNT_W-1:0] n;
    n = '0;
    for (int k = 0; k < `WBFS_WB_ENTRIES; k++) begin
      n = n + `WBFS_CNT_W'(v[k]);
    end
    return n;
  endfunction

  // Drop marked bytes of one operation into its quadword of a block
  function automatic wbfs_pkg::wbfs_entry_t wbfs_place(input wbfs_pkg::wbfs_entry_t e,
                                                       input wbfs_pkg::wbfs_memop_t op);
    wbfs_pkg::wbfs_entry_t r;
    logic [`WBFS_BEAT_W-1:0] q;
    r = e;
    q = op.addr[`WBFS_QW_MSB:`WBFS_QW_LSB];
    for (int b = 0; b < `WBFS_QW_BYTES; b++) begin
      if (op.mask[b]) begin
        r.data[q][b*`WBFS_BYTE_W +: `WBFS_BYTE_W] = op.data[b*`WBFS_BYTE_W +: `WBFS_BYTE_W];
        r.mask[q][b] = 1'b1;
      end
    end
    return r;
  endfunction

  // Write buffer state
  wbfs_pkg::wbfs_entry_t ent [`WBFS_WB_ENTRIES]; // Entry contents
  wbfs_pkg::wbfs_entry_t next_ent [`WBFS_WB_ENTRIES];
  logic [`WBFS_WB_ENTRIES-1:0] valid, next_valid; // Nonempty marks
  logic [`WBFS_PTR_W-1:0] head, next_head; // Oldest entry
  logic [`WBFS_PTR_W-1:0] tail, next_tail; // Next insert slot
  logic [`WBFS_IDLE_W-1:0] idle, next_idle; // Cycles since last insert
  logic flush, next_flush; // Drain-all request after a matching miss
  // Fill and miss state
  wbfs_fill_t fill_state, next_fill_state;
  logic miss_wait, next_miss_wait; // Requested quadword not yet back
  logic [`WBFS_BLK_W-1:0] fill_blk, next_fill_blk;
  logic [`WBFS_BEAT_W-1:0] fill_qw, next_fill_qw; // Requested quadword
  logic [`WBFS_BEATS-1:0][`WBFS_QW_W-1:0] latch, next_latch; // Pending fill
  logic next_miss_qw_valid;
  logic [`WBFS_QW_W-1:0] next_miss_qw;
  // Arbiter state
  wbfs_arb_t arb_state, next_arb_state;
  wbfs_pkg::wbfs_cmd_t cmd, next_cmd;
  logic [`WBFS_BEAT_W-1:0] beat, next_beat; // Transfer within a block
  logic next_ic_valid;
  logic [`WBFS_QW_W-1:0] next_ic_beat;
  // Silo wiring
  logic silo_in_valid, silo_in_ready, silo_out_valid, silo_out_ready;
  wbfs_pkg::wbfs_memop_t silo_out;
  // Shared decisions
  logic [`WBFS_CNT_W-1:0] cnt;
  logic is_load, direct_ok, wb_in_valid, wb_accept, merge_hit, wb_lock;
  logic start_miss, blk_in_wb, wb_sync, wb_req, dfill_req, wb_pop, rbeat;
  logic [`WBFS_PTR_W-1:0] merge_idx;
  wbfs_pkg::wbfs_memop_t wb_in_op, miss_op;

  // Silo holds operations behind an outstanding miss, oldest first
  wbfs_fifo #(
    .WIDTH($bits(wbfs_pkg::wbfs_memop_t)),
    .DEPTH(`WBFS_SILO_DEPTH)
  ) u_silo (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .in_valid_i(silo_in_valid),
    .in_ready_o(silo_in_ready),
    .in_data_i(mem_op_i),
    .out_valid_o(silo_out_valid),
    .out_ready_i(silo_out_ready),
    .out_data_o(silo_out)
  );

  // Steering of pipeline operations: direct, siloed or completed as hits
  always_comb begin
    cnt = wbfs_count(valid);
    is_load = (mem_op_i.kind == wbfs_pkg::WBFS_K_LOAD);
    // Direct path only with nothing ahead of it
    direct_ok = !silo_out_valid && !miss_wait && (!is_load || fill_state == WBFS_F_IDLE);
    // Head of silo goes to the buffer or starts the next fetch
    wb_in_valid = 1'b0;
    wb_in_op = mem_op_i;
    start_miss = 1'b0;
    miss_op = mem_op_i;
    silo_out_ready = 1'b0;
    if (silo_out_valid && !miss_wait) begin
      if (silo_out.kind == wbfs_pkg::WBFS_K_LOAD) begin
        start_miss = (fill_state == WBFS_F_IDLE); // R17
        miss_op = silo_out;
        silo_out_ready = start_miss;
      end else begin
        wb_in_valid = 1'b1; // R18
        wb_in_op = silo_out;
      end
    end else if (mem_valid_i && direct_ok) begin
      wb_in_valid = !is_load;
      start_miss = is_load && !mem_hit_i;
    end
    // Merge search; the entry being unloaded is locked
    wb_lock = (cmd.src == wbfs_pkg::WBFS_S_WB) && (arb_state != WBFS_A_IDLE);
    merge_hit = 1'b0;
    merge_idx = '0;
    blk_in_wb = 1'b0;
    wb_sync = 1'b0;
    for (int i = 0; i < `WBFS_WB_ENTRIES; i++) begin
      if (valid[i] && ent[i].kind == wbfs_pkg::WBFS_K_STORE
          && wb_in_op.kind == wbfs_pkg::WBFS_K_STORE
          && ent[i].blk == wb_in_op.addr[`WBFS_ADDR_W-1:`WBFS_BLK_LSB]
          && !(wb_lock && head == `WBFS_PTR_W'(i))) begin
        merge_hit = 1'b1; // R7 R9
        merge_idx = `WBFS_PTR_W'(i);
      end
      if (valid[i] && ent[i].blk == miss_op.addr[`WBFS_ADDR_W-1:`WBFS_BLK_LSB]) begin
        blk_in_wb = 1'b1;
      end
      if (valid[i] && (ent[i].kind == wbfs_pkg::WBFS_K_BARRIER
          || ent[i].kind == wbfs_pkg::WBFS_K_STC_Q || ent[i].kind == wbfs_pkg::WBFS_K_STC_L)) begin
        wb_sync = 1'b1;
      end
    end
    wb_accept = merge_hit || !valid[tail]; // R6
    if (silo_out_valid && !miss_wait && silo_out.kind != wbfs_pkg::WBFS_K_LOAD) begin
      silo_out_ready = wb_accept;
    end
    // Hits finish at once; misses and stores wait in the silo when needed
    silo_in_valid = mem_valid_i && !(is_load && mem_hit_i) && !direct_ok; // R15 R16
    if (!mem_valid_i || (is_load && mem_hit_i)) begin
      mem_ready_o = 1'b1;
    end else if (direct_ok) begin
      mem_ready_o = is_load || wb_accept;
    end else begin
      mem_ready_o = silo_in_ready;
    end
    // Hold address-unit issue until silo empty and quadword back
    issue_hold_o = issue_abox_i && !issue_jsr_zero_i && (miss_wait || silo_out_valid); // R14 R21
    // Unload conditions for the head entry
    wb_req = (cnt >= `WBFS_CNT_TWO) // R10
        || (cnt == `WBFS_CNT_ONE && idle >= `WBFS_IDLE_CYCLES) // R11
        || wb_sync // R12
        || (flush && cnt != '0); // R13
    // A fill waits while the buffer drains so it cannot read stale data
    dfill_req = (fill_state == WBFS_F_REQ) && !flush;
  end

  // Write buffer next state
  always_comb begin
    next_ent = ent;
    next_valid = valid;
    next_head = head;
    next_tail = tail;
    next_idle = idle;
    next_flush = flush;
    if (wb_pop) begin
      next_valid[head] = 1'b0;
      next_head = head + 1'b1; // R5 R8
    end
    if (wb_in_valid && wb_accept) begin
      if (merge_hit) begin
        next_ent[merge_idx] = wbfs_place(ent[merge_idx], wb_in_op); // R7
      end else begin
        next_ent[tail] = wbfs_place('{kind: wb_in_op.kind,
            blk: wb_in_op.addr[`WBFS_ADDR_W-1:`WBFS_BLK_LSB], data: '0, mask: '0}, wb_in_op); // R4 R9
        next_valid[tail] = 1'b1;
        next_tail = tail + 1'b1; // R5
      end
      next_idle = '0;
    end else if (idle < `WBFS_IDLE_CYCLES) begin
      next_idle = idle + 1'b1; // R11
    end
    // Set wins over the clear when both fall in one cycle
    if (cnt == '0) begin
      next_flush = 1'b0;
    end
    if (start_miss && blk_in_wb) begin
      next_flush = 1'b1; // R13
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < `WBFS_WB_ENTRIES; i++) begin
        ent[i] <= '0;
      end
      valid <= '0; // R23
      head <= '0;
      tail <= '0;
      idle <= '0;
      flush <= 1'b0;
    end else begin
      ent <= next_ent;
      valid <= next_valid;
      head <= next_head;
      tail <= next_tail;
      idle <= next_idle;
      flush <= next_flush;
    end
  end

  // Arbiter and transfer sequencing toward the bus interface unit
  always_comb begin
    next_arb_state = arb_state;
    next_cmd = cmd;
    next_beat = beat;
    wb_pop = 1'b0;
    next_ic_valid = 1'b0;
    next_ic_beat = ic_beat_o;
    rbeat = (arb_state == WBFS_A_DATA) && biu_rvalid_i && cmd.src != wbfs_pkg::WBFS_S_WB;
    biu_wvalid_o = (arb_state == WBFS_A_DATA) && cmd.src == wbfs_pkg::WBFS_S_WB; // R3
    biu_wdata_o = ent[head].data[beat];
    case (arb_state)
      WBFS_A_IDLE: begin
        next_beat = '0;
        if (dfill_req) begin
          next_cmd = '{valid: 1'b1, src: wbfs_pkg::WBFS_S_DFILL, kind: wbfs_pkg::WBFS_K_LOAD,
              blk: fill_blk, mask: '1}; // R1
          next_arb_state = WBFS_A_CMD;
        end else if (ifill_req_i) begin
          next_cmd = '{valid: 1'b1, src: wbfs_pkg::WBFS_S_IFILL, kind: wbfs_pkg::WBFS_K_LOAD,
              blk: ifill_blk_i, mask: '1}; // R1
          next_arb_state = WBFS_A_CMD;
        end else if (wb_req) begin
          next_cmd = '{valid: 1'b1, src: wbfs_pkg::WBFS_S_WB, kind: ent[head].kind,
              blk: ent[head].blk, mask: ent[head].mask}; // R1 R8
          next_arb_state = WBFS_A_CMD;
        end
      end
      WBFS_A_CMD: begin
        if (biu_cmd_ack_i) begin
          next_cmd.valid = 1'b0;
          // Commands without data finish on acceptance
          if (cmd.src == wbfs_pkg::WBFS_S_WB && cmd.kind != wbfs_pkg::WBFS_K_STORE) begin
            wb_pop = 1'b1;
            next_cmd.src = wbfs_pkg::WBFS_S_NONE;
            next_arb_state = WBFS_A_IDLE;
          end else begin
            next_arb_state = WBFS_A_DATA;
          end
        end
      end
      WBFS_A_DATA: begin
        if ((biu_wvalid_o && biu_wready_i) || rbeat) begin
          next_beat = beat + 1'b1; // R2 R3
          if (beat == `WBFS_LAST_BEAT) begin
            wb_pop = biu_wvalid_o;
            next_cmd.src = wbfs_pkg::WBFS_S_NONE;
            next_arb_state = WBFS_A_IDLE;
          end
        end
        if (rbeat && cmd.src == wbfs_pkg::WBFS_S_IFILL) begin
          next_ic_valid = 1'b1;
          next_ic_beat = biu_rdata_i;
        end
      end
      default: begin
        next_arb_state = WBFS_A_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      arb_state <= WBFS_A_IDLE;
      cmd <= '0;
      beat <= '0;
      ic_beat_valid_o <= 1'b0;
      ic_beat_o <= '0;
    end else begin
      arb_state <= next_arb_state;
      cmd <= next_cmd;
      beat <= next_beat;
      ic_beat_valid_o <= next_ic_valid;
      ic_beat_o <= next_ic_beat;
    end
  end

  // Miss tracking and the pending fill latch
  always_comb begin
    next_fill_state = fill_state;
    next_miss_wait = miss_wait;
    next_fill_blk = fill_blk;
    next_fill_qw = fill_qw;
    next_latch = latch;
    next_miss_qw_valid = 1'b0;
    next_miss_qw = miss_qw_o;
    dc_fill_we_o = 1'b0;
    case (fill_state)
      WBFS_F_IDLE: begin
        if (start_miss) begin
          next_miss_wait = 1'b1;
          next_fill_blk = miss_op.addr[`WBFS_ADDR_W-1:`WBFS_BLK_LSB];
          next_fill_qw = miss_op.addr[`WBFS_QW_MSB:`WBFS_QW_LSB];
          next_fill_state = WBFS_F_REQ;
        end
      end
      WBFS_F_REQ: begin
        if (dfill_req && arb_state == WBFS_A_IDLE) begin
          next_fill_state = WBFS_F_COLLECT;
        end
      end
      WBFS_F_COLLECT: begin
        if (rbeat && cmd.src == wbfs_pkg::WBFS_S_DFILL) begin
          // Beats wrap from the requested quadword; gaps are allowed
          next_latch[fill_qw + beat] = biu_rdata_i; // R19 R20
          if (beat == '0) begin
            next_miss_wait = 1'b0; // R21
            next_miss_qw_valid = 1'b1;
            next_miss_qw = biu_rdata_i;
          end
          if (beat == `WBFS_LAST_BEAT) begin
            next_fill_state = WBFS_F_WRITE; // R2
          end
        end
      end
      WBFS_F_WRITE: begin
        if (!dc_busy_i) begin
          dc_fill_we_o = 1'b1; // R22
          next_fill_state = WBFS_F_IDLE;
        end
      end
      default: begin
        next_fill_state = WBFS_F_IDLE;
      end
    endcase
    biu_cmd_o = cmd;
    dc_fill_blk_o = fill_blk;
    dc_fill_line_o = latch;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fill_state <= WBFS_F_IDLE;
      miss_wait <= 1'b0; // R23
      fill_blk <= '0;
      fill_qw <= '0;
      latch <= '0;
      miss_qw_valid_o <= 1'b0;
      miss_qw_o <= '0;
    end else begin
      fill_state <= next_fill_state;
      miss_wait <= next_miss_wait;
      fill_blk <= next_fill_blk;
      fill_qw <= next_fill_qw;
      latch <= next_latch;
      miss_qw_valid_o <= next_miss_qw_valid;
      miss_qw_o <= next_miss_qw;
    end
  end

  // Checks on the buffer, arbiter and fill sequencing
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_arb_dfill_first: assert property ((arb_state == WBFS_A_IDLE && dfill_req) // R1
      |=> (cmd.src == wbfs_pkg::WBFS_S_DFILL && cmd.valid)) else $error("fill not first");
  a_fill_four_beats: assert property ((fill_state == WBFS_F_COLLECT && rbeat // R2
      && cmd.src == wbfs_pkg::WBFS_S_DFILL && beat == `WBFS_LAST_BEAT)
      |=> fill_state == WBFS_F_WRITE) else $error("line not closed after four beats");
  a_wb_unload_end: assert property ((biu_wvalid_o && biu_wready_i && beat == `WBFS_LAST_BEAT) // R3
      |=> (arb_state == WBFS_A_IDLE && head == $past(head) + 1'b1)) else $error("unload end");
  a_ptr_equal_case: assert property ((head == tail) |-> (cnt == '0 || cnt == `WBFS_CNT_FULL)) // R6
      else $error("pointer meaning lost");
  a_tail_step: assert property ((wb_in_valid && wb_accept && !merge_hit) // R5
      |=> (tail == $past(tail) + 1'b1 && valid[$past(tail)])) else $error("tail did not step");
  a_req_two_entries: assert property ((cnt >= `WBFS_CNT_TWO) |-> wb_req) // R10
      else $error("two entries without request");
  a_req_idle_limit: assert property ((cnt == `WBFS_CNT_ONE && idle == `WBFS_IDLE_CYCLES) // R11
      |-> wb_req) else $error("lone entry not pushed");
  a_req_sync_cmd: assert property (wb_sync |-> wb_req) else $error("sync entry held"); // R12
  a_flush_drain: assert property ((start_miss && blk_in_wb) |=> flush) // R13
      else $error("flush not raised");
  a_issue_hold_miss: assert property ((miss_wait && issue_abox_i && !issue_jsr_zero_i) // R14
      |-> issue_hold_o) else $error("issue not held");
  a_line_write_free: assert property ((fill_state == WBFS_F_WRITE && !dc_busy_i) // R22
      |-> dc_fill_we_o ##1 fill_state == WBFS_F_IDLE) else $error("line write missed");
  a_reset_clear_all: assert property (disable iff (1'b0) srst_i // R23
      |=> (valid == '0 && head == tail && idle == '0)) else $error("reset state wrong");

  c_store_merge: cover property (wb_in_valid && wb_accept && merge_hit);
  c_buffer_full: cover property (cnt == `WBFS_CNT_FULL);
  c_silo_replay: cover property (silo_out_valid && silo_out_ready);
  c_fill_done: cover property (dc_fill_we_o);
endmodule

// file: hdl/wbfs_params.svh
// Purpose: Shared constants for the write buffer and fill silo block
// Assumes: Included by bare name from every design file
// Notes: Counts and field positions only; types live in the package
`ifndef WBFS_PARAMS_SVH
`define WBFS_PARAMS_SVH
// Internal path is one quadword wide
`define WBFS_QW_W 64
// Bytes per quadword and bits per byte
`define WBFS_QW_BYTES 8
`define WBFS_BYTE_W 8
// Quadword transfers per 32-byte block
`define WBFS_BEATS 4
`define WBFS_BEAT_W 2
`define WBFS_LAST_BEAT 2'h3
// Byte address field positions
`define WBFS_ADDR_W 32
`define WBFS_BLK_LSB 5
`define WBFS_BLK_W 27
`define WBFS_QW_LSB 3
`define WBFS_QW_MSB 4
// Write buffer geometry
`define WBFS_WB_ENTRIES 4
`define WBFS_PTR_W 2
`define WBFS_CNT_W 3
`define WBFS_CNT_FULL 3'h4
`define WBFS_CNT_TWO 3'h2
`define WBFS_CNT_ONE 3'h1
// Idle cycles before a lone entry is pushed out
`define WBFS_IDLE_W 9
`define WBFS_IDLE_CYCLES 9'h100
// Silo depth
`define WBFS_SILO_DEPTH 8
`endif

// file: hdl/wbfs_pkg.sv
// Purpose: Types shared by the write buffer and fill silo block
// Assumes: wbfs_params.svh supplies the widths
// Notes: Nothing here is imported; users write wbfs_pkg::name
`include "wbfs_params.svh"
package wbfs_pkg;
  // Kind of memory operation leaving the address pipeline
  typedef enum logic [2:0] {
    WBFS_K_LOAD, WBFS_K_STORE, WBFS_K_BARRIER, WBFS_K_STC_Q, WBFS_K_STC_L, WBFS_K_FETCH
  } wbfs_kind_t;
  // Owner of a transfer toward the bus interface unit
  typedef enum logic [1:0] {WBFS_S_NONE, WBFS_S_DFILL, WBFS_S_IFILL, WBFS_S_WB} wbfs_src_t;
  // One memory operation at the cache hit stage
  typedef struct packed {
    wbfs_kind_t kind;
    logic [`WBFS_ADDR_W-1:0] addr;
    logic [`WBFS_QW_W-1:0] data;
    logic [`WBFS_QW_BYTES-1:0] mask;
  } wbfs_memop_t;
  // One write buffer entry: an aligned block with byte marks
  typedef struct packed {
    wbfs_kind_t kind;
    logic [`WBFS_BLK_W-1:0] blk;
    logic [`WBFS_BEATS-1:0][`WBFS_QW_W-1:0] data;
    logic [`WBFS_BEATS-1:0][`WBFS_QW_BYTES-1:0] mask;
  } wbfs_entry_t;
  // Command to the bus interface unit
  typedef struct packed {
    logic valid;
    wbfs_src_t src;
    wbfs_kind_t kind;
    logic [`WBFS_BLK_W-1:0] blk;
    logic [`WBFS_BEATS-1:0][`WBFS_QW_BYTES-1:0] mask;
  } wbfs_cmd_t;
endpackage

// file: hdl/wbfs_fifo.sv
// Purpose: Small synchronous FIFO used as the load miss silo
// Assumes: One clock, synchronous active high reset
// Notes: Output data comes straight from the storage array
`timescale 1ns/100ps
`include "wbfs_params.svh"
module wbfs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `WBFS_SILO_DEPTH
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage array
  logic [AW-1:0] rd_ptr, next_rd_ptr; // Oldest word
  logic [AW-1:0] wr_ptr, next_wr_ptr; // Next free slot
  logic [AW:0] count, next_count; // Words held
  logic push, pop;

  // Handshakes; full and empty come from the count
  always_comb begin
    in_ready_o = (count != (AW+1)'(DEPTH));
    out_valid_o = (count != '0);
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    out_data_o = mem[rd_ptr];
  end

  // Pointers and count
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count <= '0;
    end else begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count <= next_count;
    end
  end

  // Array write; no reset needed since count guards reads
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule

// file: tb/wbfs_biu_model.sv
// Purpose: Behavioural bus interface unit facing the write buffer block
// Assumes: One clock; slow_i adds random stalls on read and write beats
// Notes: Logs accepted commands and taken write beats for the bench
`timescale 1ns/100ps
`include "wbfs_params.svh"
module wbfs_biu_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic slow_i,
  input wire wbfs_pkg::wbfs_cmd_t cmd_i,
  output logic ack_o,
  output logic rvalid_o,
  output logic [63:0] rdata_o,
  input wire logic wvalid_i,
  input wire logic [63:0] wdata_i,
  output logic wready_o
);
  wbfs_pkg::wbfs_cmd_t cq[$]; // Accepted commands, oldest first
  logic [63:0] wq[$]; // Write beats taken, oldest first
  int beats = 0; // Read beats still owed
  int k = 0; // Index of the next read beat
  logic [26:0] blk = '0; // Block of the running fill
  initial {ack_o, rvalid_o, wready_o, rdata_o} = '0;
  // One command at a time; a fill is answered only after its ack
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rvalid_o <= 1'b0;
    rdata_o <= ~rdata_o; // Idle data line toggles so stale data never looks valid
    wready_o <= !slow_i || $urandom_range(1);
    if (wvalid_i && wready_o) wq.push_back(wdata_i);
    if (srst_i) begin
      beats <= 0;
    end else if (cmd_i.valid && ack_o) begin
      cq.push_back(cmd_i);
      blk <= cmd_i.blk;
      k <= 0;
      if (cmd_i.src != wbfs_pkg::WBFS_S_WB) beats <= 4;
    end else if (cmd_i.valid && beats == 0) begin
      ack_o <= 1'b1;
    end else if (beats > 0 && (!slow_i || $urandom_range(1))) begin
      rvalid_o <= 1'b1;
      rdata_o <= {5'h00, blk, 32'(k)};
      k <= k + 1;
      beats <= beats - 1;
    end
  end
endmodule

// file: tb/wbfs_top_tb.sv
// Purpose: Self-checking bench for the write buffer and fill silo block
// Assumes: Partner model answers on the bus unit side
// Notes: Loads miss except one driven as a hit; expectations come from block and quadword math
`timescale 1ns/100ps
`include "wbfs_params.svh"
module wbfs_top_tb;
  logic clk_i = 0, srst_i = 1, issue_abox_i = 0, issue_jsr_zero_i = 0, mem_valid_i = 0;
  logic mem_hit_i = 0, ifill_req_i = 0, dc_busy_i = 0, slow = 0;
  logic [26:0] ifill_blk_i = '0, dc_fill_blk_o, b;
  wbfs_pkg::wbfs_memop_t mem_op_i = '0;
  logic issue_hold_o, mem_ready_o, miss_qw_valid_o, ic_beat_valid_o, dc_fill_we_o;
  logic biu_cmd_ack_i, biu_rvalid_i, biu_wvalid_o, biu_wready_i;
  logic [63:0] miss_qw_o, ic_beat_o, biu_rdata_i, biu_wdata_o, d, d2;
  logic [255:0] dc_fill_line_o;
  wbfs_pkg::wbfs_cmd_t biu_cmd_o;
  wbfs_pkg::wbfs_kind_t ks[4] = '{wbfs_pkg::WBFS_K_BARRIER, wbfs_pkg::WBFS_K_STC_Q,
    wbfs_pkg::WBFS_K_STC_L, wbfs_pkg::WBFS_K_FETCH}; // Kinds that never merge
  int failures = 0, checked = 0, nfill = 0, nic = 0, nmq = 0, n;
  always #25 clk_i = ~clk_i;
  wbfs_top uut (.*);
  wbfs_biu_model biu (.clk_i(clk_i), .srst_i(srst_i), .slow_i(slow), .cmd_i(biu_cmd_o),
    .ack_o(biu_cmd_ack_i), .rvalid_o(biu_rvalid_i), .rdata_o(biu_rdata_i),
    .wvalid_i(biu_wvalid_o), .wdata_i(biu_wdata_o), .wready_o(biu_wready_i));
  // Count line writes and instruction beats as they pulse
  always @(posedge clk_i) begin
    nfill <= nfill + dc_fill_we_o;
    nic <= nic + ic_beat_valid_o;
    nmq <= nmq + miss_qw_valid_o;
  end
  // Fill request is a level held until the first beat shows
  always @(negedge clk_i) if (ic_beat_valid_o) ifill_req_i <= 1'b0;
  task automatic chk(string nm, logic [63:0] s, logic [63:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // A used-up bound counts as a mismatch and ends the run
  task automatic tmo(int m);
    if (m >= 600) begin
      failures++;
      $display("ERROR wait bound expired");
      final_report();
    end
  endtask
  // Present one op at a falling edge and hold it until it is taken
  task automatic op(wbfs_pkg::wbfs_kind_t k, logic [26:0] ob, logic [1:0] q, logic [63:0] od);
    bit ok = 0;
    mem_op_i = '{kind: k, addr: {ob, q, 3'h0}, data: od, mask: 8'hff};
    mem_valid_i = 1'b1;
    for (n = 0; n < 600 && !ok; n++) begin
      #1 ok = (mem_ready_o === 1'b1);
      @(negedge clk_i);
    end
    mem_valid_i = 1'b0;
    tmo(n);
  endtask
  // Wait until the partner has logged enough commands and write beats
  task automatic waitlog(int c, int w);
    for (n = 0; n < 600 && (biu.cq.size() < c || biu.wq.size() < w); n++) @(negedge clk_i);
    tmo(n);
    biu.cq.delete();
    biu.wq.delete();
  endtask
  initial begin
    void'($urandom(32'he852_95c7));
    repeat (4) @(negedge clk_i);
    srst_i = 0;
    chk("cmd_valid", biu_cmd_o.valid, 1'h0);
    chk("wvalid", biu_wvalid_o, 1'h0);
    $display("test reset done");
    // Two blocks, slow far side: both leave in insertion order
    slow = 1;
    b = 27'($urandom);
    d = {$urandom, $urandom};
    d2 = {$urandom, $urandom};
    op(wbfs_pkg::WBFS_K_STORE, b, 2'h1, d);
    op(wbfs_pkg::WBFS_K_STORE, b + 27'h1, 2'h2, d2);
    for (n = 0; n < 600 && (biu.cq.size() < 2 || biu.wq.size() < 8); n++) @(negedge clk_i);
    tmo(n);
    chk("blk_first", biu.cq[0].blk, b);
    chk("blk_second", biu.cq[1].blk, b + 27'h1);
    chk("beat_first", biu.wq[1], d);
    chk("beat_second", biu.wq[6], d2);
    waitlog(0, 0);
    $display("test order done");
    // Merged stores then each special kind in an entry of its own
    for (int i = 0; i < 4; i++) begin
      b = 27'($urandom);
      op(wbfs_pkg::WBFS_K_STORE, b, 2'h0, d);
      op(wbfs_pkg::WBFS_K_STORE, b, 2'h3, d2);
      op(ks[i], b, 2'h0, d);
      for (n = 0; n < 600 && (biu.cq.size() < 2 || biu.wq.size() < 4); n++) @(negedge clk_i);
      tmo(n);
      chk("special_kind", biu.cq[1].kind, ks[i]);
      chk("merge_lo", biu.wq[0], d);
      chk("merge_hi", biu.wq[3], d2);
      waitlog(0, 0);
    end
    $display("test merge done");
    // A lone entry waits out the idle limit
    op(wbfs_pkg::WBFS_K_STORE, b, 2'h0, d);
    repeat (250) @(negedge clk_i);
    chk("lone_early", biu.cq.size(), 64'h0);
    waitlog(1, 4);
    $display("test idle done");
    // Load miss with an instruction fill queued behind it, array busy
    slow = 0;
    dc_busy_i = 1;
    b = 27'($urandom);
    op(wbfs_pkg::WBFS_K_LOAD, b, 2'h2, d);
    ifill_blk_i = b + 27'h1;
    ifill_req_i = 1;
    issue_abox_i = 1;
    #1 chk("hold_miss", issue_hold_o, 1'h1);
    issue_jsr_zero_i = 1;
    #1 chk("hold_jsr", issue_hold_o, 1'h0);
    issue_jsr_zero_i = 0;
    mem_hit_i = 1;
    op(wbfs_pkg::WBFS_K_LOAD, b + 27'h2, 2'h0, d);
    mem_hit_i = 0;
    chk("hit_no_silo", uut.silo_out_valid, 1'h0);
    for (n = 0; n < 600 && (biu.cq.size() < 2 || nic < 4); n++) @(negedge clk_i);
    tmo(n);
    chk("fill_first", biu.cq[0].src, wbfs_pkg::WBFS_S_DFILL);
    chk("fill_second", biu.cq[1].src, wbfs_pkg::WBFS_S_IFILL);
    chk("miss_qw", miss_qw_o, {5'h00, b, 32'h0});
    chk("miss_pulse", nmq, 64'h1);
    chk("ic_last", ic_beat_o, {5'h00, b + 27'h1, 32'h3});
    chk("hold_done", issue_hold_o, 1'h0);
    chk("busy_wait", nfill, 64'h0);
    dc_busy_i = 0;
    for (n = 0; n < 600 && nfill < 1; n++) @(negedge clk_i);
    tmo(n);
    chk("fill_blk", dc_fill_blk_o, b);
    for (int k = 0; k < 4; k++) chk("line_qw", dc_fill_line_o[((2 + k) % 4) * 64 +: 64],
      {5'h00, b, 32'(k)});
    $display("test fill done");
    final_report();
  end
endmodule
